// ---- pkg/gpio_port_pkg.sv ----
// Shared constants for the port A I/O block: register map, reset values,
// steering bit positions and bus response codes.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses.
package gpio_port_pkg;

  // ****************************************************
  // Widths
  // ****************************************************
  localparam int ADDR_W = 8;              // Register bus address width
  localparam int DATA_W = 32;             // Register bus data width
  localparam int PORT_W = 8;              // Pins of port A
  localparam int GUARD_W = 4;             // Port B guard pins 4..7

  // ****************************************************
  // Register offsets (byte addresses)
  // ****************************************************
  localparam logic [ADDR_W-1:0] OFS_PIN_LEVEL = 8'h00;  // pin_level_reg_a
  localparam logic [ADDR_W-1:0] OFS_LATCH     = 8'h04;  // output_latch_a
  localparam logic [ADDR_W-1:0] OFS_DIR       = 8'h08;  // dir_reg_a
  localparam logic [ADDR_W-1:0] OFS_ANALOG    = 8'h0c;  // analog_select_a
  localparam logic [ADDR_W-1:0] OFS_STEER     = 8'h10;  // pin_steering_control

  // ****************************************************
  // Reset values and masks
  // ****************************************************
  localparam logic [PORT_W-1:0] RST_LATCH  = 8'h00;
  localparam logic [PORT_W-1:0] RST_DIR    = 8'hff;  // All pins input
  localparam logic [PORT_W-1:0] RST_ANALOG = 8'hff;  // All pins analog
  localparam logic [PORT_W-1:0] RST_STEER  = 8'h00;
  localparam logic [PORT_W-1:0] STEER_MASK = 8'h23;  // Implemented steering bits
  localparam logic [PORT_W-1:0] IN_ONLY_MASK = 8'h08; // Input-only pin mask
  localparam logic [DATA_W-PORT_W-1:0] RD_PAD = 24'h000000; // Upper read bits

  // ****************************************************
  // Bit positions
  // ****************************************************
  localparam int SS_ROUTE_BIT   = 5;  // slave_select_route
  localparam int GUARD_B_BIT    = 1;  // guard_b_route
  localparam int GUARD_A_BIT    = 0;  // guard_a_route
  localparam int IN_ONLY_PIN    = 3;  // port_a_bit3
  localparam int SS_PIN_SET     = 0;  // port_a_bit0
  localparam int SS_PIN_CLR     = 5;  // port_a_bit5
  localparam int GPIN_B4        = 0;  // Guard vector index of port_b_bit4
  localparam int GPIN_B5        = 1;  // port_b_bit5
  localparam int GPIN_B6        = 2;  // port_b_bit6
  localparam int GPIN_B7        = 3;  // port_b_bit7

  // ****************************************************
  // Bus responses
  // ****************************************************
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Decode shared by read and write paths
  function automatic logic isMapped(input logic [ADDR_W-1:0] a);
    return (a == OFS_PIN_LEVEL) || (a == OFS_LATCH) || (a == OFS_DIR) ||
           (a == OFS_ANALOG) || (a == OFS_STEER);
  endfunction

endpackage

// ---- rtl/axi_lite_regs_slave.sv ----
// AXI4-Lite slave front end: turns bus transfers into register strobes.
// Assumes the register file answers reads combinationally from rdAddr.
`timescale 1ns/10ps
module axi_lite_regs_slave (
  input  wire logic                              clk_sys,
  input  wire logic                              nrst,
  input  wire logic [gpio_port_pkg::ADDR_W-1:0]  awaddr,
  input  wire logic                              awvalid,
  output logic                                   awready,
  input  wire logic [gpio_port_pkg::DATA_W-1:0]  wdata,
  input  wire logic [3:0]                        wstrb,
  input  wire logic                              wvalid,
  output logic                                   wready,
  output logic [1:0]                             bresp,
  output logic                                   bvalid,
  input  wire logic                              bready,
  input  wire logic [gpio_port_pkg::ADDR_W-1:0]  araddr,
  input  wire logic                              arvalid,
  output logic                                   arready,
  output logic [gpio_port_pkg::DATA_W-1:0]       rdata,
  output logic [1:0]                             rresp,
  output logic                                   rvalid,
  input  wire logic                              rready,
  output logic                                   wrEn,
  output logic [gpio_port_pkg::ADDR_W-1:0]       wrAddr,
  output logic [gpio_port_pkg::DATA_W-1:0]       wrData,
  output logic [3:0]                             wrStrb,
  output logic [gpio_port_pkg::ADDR_W-1:0]       rdAddr,
  input  wire logic [gpio_port_pkg::DATA_W-1:0]  rdData
);
  import gpio_port_pkg::*;

  // ****************************************************
  // State
  // ****************************************************
  logic              awFull, next_awFull;   // Write address held
  logic              wFull, next_wFull;     // Write data held
  logic [ADDR_W-1:0] awAddrQ, next_awAddrQ; // Held write address
  logic [DATA_W-1:0] wDataQ, next_wDataQ;   // Held write data
  logic [3:0]        wStrbQ, next_wStrbQ;   // Held strobes
  logic              next_bvalid;
  logic [1:0]        next_bresp;
  logic              next_rvalid;
  logic [DATA_W-1:0] next_rdata;
  logic [1:0]        next_rresp;
  logic              fire;                  // Both halves present
  logic              arTake;                // Read address taken

  // Each half is taken independently; one write at a time
  assign awready = !awFull;
  assign wready  = !wFull;
  assign arready = !rvalid;
  assign fire    = awFull && wFull && !bvalid;
  assign arTake  = arvalid && !rvalid;
  assign wrEn    = fire && isMapped(awAddrQ);
  assign wrAddr  = awAddrQ;
  assign wrData  = wDataQ;
  assign wrStrb  = wStrbQ;
  assign rdAddr  = araddr;

  // Next-state of both channels
  always_comb begin
    next_awFull  = (awFull && !fire) || (awvalid && !awFull);
    next_wFull   = (wFull && !fire) || (wvalid && !wFull);
    next_awAddrQ = (awvalid && !awFull) ? awaddr : awAddrQ;
    next_wDataQ  = (wvalid && !wFull) ? wdata : wDataQ;
    next_wStrbQ  = (wvalid && !wFull) ? wstrb : wStrbQ;
    next_bvalid  = fire || (bvalid && !bready);
    next_bresp   = bresp;
    if (fire) begin
      // Unmapped address answers with an error and writes nothing
      next_bresp = isMapped(awAddrQ) ? RESP_OKAY : RESP_SLVERR;
    end
    next_rvalid = arTake || (rvalid && !rready);
    next_rdata  = rdata;
    next_rresp  = rresp;
    if (arTake) begin
      next_rdata = isMapped(araddr) ? rdData : '0;
      next_rresp = isMapped(araddr) ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // Register stage
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      awFull  <= 1'b0;
      wFull   <= 1'b0;
      awAddrQ <= '0;
      wDataQ  <= '0;
      wStrbQ  <= '0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= RESP_OKAY;
    end else begin
      awFull  <= next_awFull;
      wFull   <= next_wFull;
      awAddrQ <= next_awAddrQ;
      wDataQ  <= next_wDataQ;
      wStrbQ  <= next_wStrbQ;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      rvalid  <= next_rvalid;
      rdata   <= next_rdata;
      rresp   <= next_rresp;
    end
  end

endmodule

// ---- rtl/pin_driver.sv ----
// Output stage of one port pin: priority between peripherals and latch.
// Assumes all inputs are synchronous to clk_sys; outputs are registered.
`timescale 1ns/10ps
module pin_driver #(
  parameter bit INPUT_ONLY = 1'b0          // Pin can never drive
) (
  input  wire logic clk_sys,
  input  wire logic nrst,
  input  wire logic hiEn,                  // Higher priority peripheral
  input  wire logic hiOut,
  input  wire logic loEn,                  // Lower priority peripheral
  input  wire logic loOut,
  input  wire logic latchBit,              // General purpose latch
  input  wire logic dirBit,                // 1 = input
  output logic      padOut,
  output logic      padOe
);
  logic next_padOut;
  logic next_padOe;

  // Highest enabled source wins; latch only when no peripheral claims the pin
  always_comb begin
    if (hiEn) begin
      next_padOut = hiOut;
    end else if (loEn) begin
      next_padOut = loOut;
    end else begin
      next_padOut = latchBit;
    end
    // Direction and INPUT_ONLY gate the driver; analog mode has no say here
    next_padOe = !dirBit && !INPUT_ONLY;
  end

  // Output flops keep pad timing clean at the cost of one cycle
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      padOut <= 1'b0;
      padOe  <= 1'b0;
    end else begin
      padOut <= next_padOut;
      padOe  <= next_padOe;
    end
  end

endmodule

// ---- rtl/io_port_with_pin_steering.sv ----
// Port A general purpose I/O with latch, direction, analog select and
// pin steering for the serial slave select and converter guard drives.
// Assumes pins and peripheral signals are synchronous to clk_sys, and
// software reaches the registers over AXI4-Lite.
//
// The AXI4-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/10ps

// Function
// - Latch write equals pin-level register write
// - Latch reads latch; pin-level reads pins
// - Analog select disables digital input buffer
// - Enabled peripheral overrides latch; pin stays readable
// - Steering never touches direction; unselected pin untouched
// - Slave select on bit0 if set, else bit5
// - Guard B routing to port B 7/6
// - Guard A routing to port B 5/4
// - Direction 1 disables driver; 0 drives latch
// - Bit 3 input only; direction reads one
// - Port writes are read-modify-write into latch
// - Direction still drives; analog reads zero
// - Analog select leaves digital outputs working
// - Analog select bits set after reset
// - Highest priority enabled output owns pin
module io_port_with_pin_steering (
  input  wire logic                                clk_sys,
  input  wire logic                                nrst,
  // AXI4-Lite register bus
  input  wire logic [gpio_port_pkg::ADDR_W-1:0]    awaddr,
  input  wire logic                                awvalid,
  output logic                                     awready,
  input  wire logic [gpio_port_pkg::DATA_W-1:0]    wdata,
  input  wire logic [3:0]                          wstrb,
  input  wire logic                                wvalid,
  output logic                                     wready,
  output logic [1:0]                               bresp,
  output logic                                     bvalid,
  input  wire logic                                bready,
  input  wire logic [gpio_port_pkg::ADDR_W-1:0]    araddr,
  input  wire logic                                arvalid,
  output logic                                     arready,
  output logic [gpio_port_pkg::DATA_W-1:0]         rdata,
  output logic [1:0]                               rresp,
  output logic                                     rvalid,
  input  wire logic                                rready,
  // Port A pads
  input  wire logic [gpio_port_pkg::PORT_W-1:0]    padIn,
  output logic [gpio_port_pkg::PORT_W-1:0]         padOut,
  output logic [gpio_port_pkg::PORT_W-1:0]         padOe,
  // Competing peripheral outputs per pin
  input  wire logic [gpio_port_pkg::PORT_W-1:0]    periphHiEn,
  input  wire logic [gpio_port_pkg::PORT_W-1:0]    periphHiOut,
  input  wire logic [gpio_port_pkg::PORT_W-1:0]    periphLoEn,
  input  wire logic [gpio_port_pkg::PORT_W-1:0]    periphLoOut,
  // Digital input view for peripherals, analog pins read zero
  output logic [gpio_port_pkg::PORT_W-1:0]         digitalIn,
  output logic [gpio_port_pkg::PORT_W-1:0]         analogSel,
  // Serial port one slave select after steering
  output logic                                     serial1SlaveSelect,
  // Converter guard drives and their enables
  input  wire logic                                conv1GuardA,
  input  wire logic                                conv2GuardA,
  input  wire logic                                conv1GuardB,
  input  wire logic                                conv2GuardB,
  input  wire logic                                conv1GuardAEn,
  input  wire logic                                conv2GuardAEn,
  input  wire logic                                conv1GuardBEn,
  input  wire logic                                conv2GuardBEn,
  // Port B bits 4..7 guard drive, index 0 is bit 4
  output logic [gpio_port_pkg::GUARD_W-1:0]        guardPinOut,
  output logic [gpio_port_pkg::GUARD_W-1:0]        guardPinEn
);
  import gpio_port_pkg::*;

  // ****************************************************
  // Bus front end
  // ****************************************************
  logic              wrEn;      // One-cycle write strobe, mapped only
  logic [ADDR_W-1:0] wrAddr;
  logic [DATA_W-1:0] wrData;
  logic [3:0]        wrStrb;
  logic [ADDR_W-1:0] rdAddr;
  logic [DATA_W-1:0] rdData;    // Combinational read mux

  axi_lite_regs_slave busSlave (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .wrEn    (wrEn),
    .wrAddr  (wrAddr),
    .wrData  (wrData),
    .wrStrb  (wrStrb),
    .rdAddr  (rdAddr),
    .rdData  (rdData)
  );

  // ****************************************************
  // Register file
  // ****************************************************
  logic [PORT_W-1:0] latch, next_latch;     // output_latch_a
  logic [PORT_W-1:0] dir, next_dir;         // dir_reg_a
  logic [PORT_W-1:0] analog, next_analog;   // analog_select_a
  logic [PORT_W-1:0] steer, next_steer;     // pin_steering_control
  logic [PORT_W-1:0] laneMask;              // Byte lane 0 written

  // Digital buffer gated off on analog pins, so they read zero
  assign digitalIn = padIn & ~analog;
  assign analogSel = analog;
  assign laneMask  = {PORT_W{wrStrb[0]}};

  // Register updates
  always_comb begin
    next_latch  = latch;
    next_dir    = dir;
    next_analog = analog;
    next_steer  = steer;
    if (wrEn) begin
      unique case (wrAddr)
        // Both addresses land in the latch by the same path
        // Pins are read, merged with the written lane, stored
        OFS_PIN_LEVEL,
        OFS_LATCH: begin
          next_latch = (digitalIn & ~laneMask) | (wrData[PORT_W-1:0] & laneMask);
        end
        // The input-only pin keeps its direction bit at one
        OFS_DIR: begin
          if (wrStrb[0]) begin
            next_dir = wrData[PORT_W-1:0] | IN_ONLY_MASK;
          end
        end
        OFS_ANALOG: begin
          if (wrStrb[0]) begin
            next_analog = wrData[PORT_W-1:0];
          end
        end
        // Unimplemented steering bits are dropped on write
        OFS_STEER: begin
          if (wrStrb[0]) begin
            next_steer = wrData[PORT_W-1:0] & STEER_MASK;
          end
        end
        default: begin
          next_latch = latch;
        end
      endcase
    end
  end

  // Register flops; analog mode after reset, digital needs software
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      latch  <= RST_LATCH;
      dir    <= RST_DIR;
      analog <= RST_ANALOG;
      steer  <= RST_STEER;
    end else begin
      latch  <= next_latch;
      dir    <= next_dir;
      analog <= next_analog;
      steer  <= next_steer;
    end
  end

  // Read mux: latch shows stored values, pin level shows the pins
  always_comb begin
    rdData = '0;
    unique case (rdAddr)
      OFS_PIN_LEVEL: rdData = {RD_PAD, digitalIn};
      OFS_LATCH:     rdData = {RD_PAD, latch};
      OFS_DIR:       rdData = {RD_PAD, dir | IN_ONLY_MASK};
      OFS_ANALOG:    rdData = {RD_PAD, analog};
      OFS_STEER:     rdData = {RD_PAD, steer & STEER_MASK};
      default:       rdData = '0;
    endcase
  end

  // ****************************************************
  // Pad drivers
  // ****************************************************
  // Peripheral beats latch, direction gates driver, analog ignored
  for (genvar i = 0; i < PORT_W; i++) begin : g_pin
    pin_driver #(
      .INPUT_ONLY (i == IN_ONLY_PIN)
    ) drv (
      .clk_sys  (clk_sys),
      .nrst     (nrst),
      .hiEn     (periphHiEn[i]),
      .hiOut    (periphHiOut[i]),
      .loEn     (periphLoEn[i]),
      .loOut    (periphLoOut[i]),
      .latchBit (latch[i]),
      .dirBit   (dir[i]),
      .padOut   (padOut[i]),
      .padOe    (padOe[i])
    );
  end

  // ****************************************************
  // Pin steering
  // ****************************************************
  logic                 next_ss;
  logic [GUARD_W-1:0]   next_guardOut;
  logic [GUARD_W-1:0]   next_guardEn;

  // Steering only moves functions; dir is never written here
  always_comb begin
    // Slave select follows its selected pin only
    next_ss = steer[SS_ROUTE_BIT] ? digitalIn[SS_PIN_SET] : digitalIn[SS_PIN_CLR];
    if (steer[GUARD_A_BIT]) begin
      next_guardOut[GPIN_B5] = conv1GuardA;
      next_guardEn[GPIN_B5]  = conv1GuardAEn;
      next_guardOut[GPIN_B4] = conv2GuardA;
      next_guardEn[GPIN_B4]  = conv2GuardAEn;
    end else begin
      next_guardOut[GPIN_B4] = conv1GuardA;
      next_guardEn[GPIN_B4]  = conv1GuardAEn;
      next_guardOut[GPIN_B5] = conv2GuardA;
      next_guardEn[GPIN_B5]  = conv2GuardAEn;
    end
    if (steer[GUARD_B_BIT]) begin
      next_guardOut[GPIN_B7] = conv1GuardB;
      next_guardEn[GPIN_B7]  = conv1GuardBEn;
      next_guardOut[GPIN_B6] = conv2GuardB;
      next_guardEn[GPIN_B6]  = conv2GuardBEn;
    end else begin
      next_guardOut[GPIN_B6] = conv1GuardB;
      next_guardEn[GPIN_B6]  = conv1GuardBEn;
      next_guardOut[GPIN_B7] = conv2GuardB;
      next_guardEn[GPIN_B7]  = conv2GuardBEn;
    end
  end

  // Steering outputs are registered, one cycle behind their sources
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      serial1SlaveSelect <= 1'b0;
      guardPinOut        <= '0;
      guardPinEn         <= '0;
    end else begin
      serial1SlaveSelect <= next_ss;
      guardPinOut        <= next_guardOut;
      guardPinEn         <= next_guardEn;
    end
  end

  // ****************************************************
  // Assertions
  // ****************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  sequence latchWrite_s;
    wrEn && wrStrb[0] && (wrAddr == OFS_PIN_LEVEL || wrAddr == OFS_LATCH);
  endsequence

  analog_read_zero_a: assert property ((digitalIn & analog) == '0)
    else $error("analog pin reads nonzero");
  input_only_pin_a: assert property (!padOe[IN_ONLY_PIN] && dir[IN_ONLY_PIN])
    else $error("input-only pin drives or dir clear");
  driver_enable_a: assert property ($past(dir[0]) |-> !padOe[0])
    else $error("driver on with dir set");
  // Registered outputs still hold reset values one edge after release, so skip it
  analog_output_a: assert property ($past(nrst && !dir[1] && analog[1]) |-> padOe[1])
    else $error("analog pin lost digital output");
  latch_drive_a: assert property ($past(nrst && !periphHiEn[2] && !periphLoEn[2]) |->
    padOut[2] == $past(latch[2]))
    else $error("latch not on pin");
  // Every pin claimed by the higher source shows that source's value
  out_priority_a: assert property ($past(nrst) |->
    (padOut & $past(periphHiEn)) == ($past(periphHiOut) & $past(periphHiEn)))
    else $error("priority not honoured");
  port_write_a: assert property (latchWrite_s |=> latch == $past(wrData[PORT_W-1:0]))
    else $error("port write not stored");
  slave_route_a: assert property ($past(nrst && steer[SS_ROUTE_BIT]) |->
    serial1SlaveSelect == $past(digitalIn[SS_PIN_SET]))
    else $error("slave select wrong pin");
  guard_a_route_a: assert property ($past(nrst && steer[GUARD_A_BIT]) |->
    guardPinOut[GPIN_B5] == $past(conv1GuardA))
    else $error("guard A routed wrong");
  guard_b_route_a: assert property ($past(nrst && !steer[GUARD_B_BIT]) |->
    guardPinOut[GPIN_B6] == $past(conv1GuardB))
    else $error("guard B routed wrong");
  steer_unused_a: assert property ((steer & ~STEER_MASK) == '0)
    else $error("unused steering bit set");
  steer_dir_a: assert property (wrEn && wrAddr == OFS_STEER |=> dir == $past(dir))
    else $error("steering changed dir");

endmodule

// ---- bench/pad_world.sv ----
// Pad model for port A: resolves each pin from the block's drive and an outside level.
// Assumes the testbench supplies the outside level on every undriven pin.
`timescale 1ns/10ps
module pad_world (
  input  wire logic [7:0] padOut,
  input  wire logic [7:0] padOe,
  input  wire logic [7:0] extLevel,
  output logic [7:0]      padIn
);
  // ****************************************************
  // Pin resolution
  // ****************************************************
  // A driven pin shows the block's value; an undriven one shows the outside level
  always_comb begin
    padIn = (padOe & padOut) | (~padOe & extLevel);
  end
endmodule

// ---- bench/io_port_with_pin_steering_bench.sv ----
// Register-level bench for the port A block over AXI4-Lite.
// Assumes pad_world resolves the pins; all checks are made against fixed expectations.
`timescale 1ns/10ps
module io_port_with_pin_steering_bench;
  import gpio_port_pkg::*;
  // ****************************************************
  // Stimulus and observation
  // ****************************************************
  logic       clk_sys, nrst, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr, padIn, padOut, padOe, hiEn, hiOut, loEn, loOut, digitalIn, analogSel, ext;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb, gVal, gEn, guardPinOut, guardPinEn;
  logic [1:0] bresp, rresp;
  logic       ss;
  int         errorCnt, comparisons;
  io_port_with_pin_steering io_port_with_pin_steering_i (.clk_sys(clk_sys), .nrst(nrst), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .padIn(padIn), .padOut(padOut),
    .padOe(padOe), .periphHiEn(hiEn), .periphHiOut(hiOut), .periphLoEn(loEn), .periphLoOut(loOut),
    .digitalIn(digitalIn), .analogSel(analogSel), .serial1SlaveSelect(ss), .conv1GuardA(gVal[0]),
    .conv2GuardA(gVal[1]), .conv1GuardB(gVal[2]), .conv2GuardB(gVal[3]), .conv1GuardAEn(gEn[0]),
    .conv2GuardAEn(gEn[1]), .conv1GuardBEn(gEn[2]), .conv2GuardBEn(gEn[3]), .guardPinOut(guardPinOut),
    .guardPinEn(guardPinEn));
  pad_world pad_world_i (.padOut(padOut), .padOe(padOe), .extLevel(ext), .padIn(padIn));
  // ****************************************************
  // Tasks
  // ****************************************************
  // One comparison; four-state equality so an unknown never matches
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errorCnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    @(posedge clk_sys);
    awaddr <= a; wdata <= d; wstrb <= s; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk(32'(bresp), 32'(er));
  endtask
  // Read and compare data and response
  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge clk_sys);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    chk(32'(rresp), 32'(er));
    rready <= 1'b0;
    chk(rd, exp);
  endtask
  // Pins follow registers one edge later; allow two and step off the edge
  task automatic settle;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask
  // Verdict and end of run
  task automatic results;
    $display("comparisons %0d errors %0d", comparisons, errorCnt);
    if (errorCnt == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ****************************************************
  // Clock, watchdog and sequence
  // ****************************************************
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // The tests need well under a thousand cycles; five thousand means a hang
  initial begin
    repeat (5000) @(posedge clk_sys);
    errorCnt++;
    results();
  end
  initial begin
    nrst = 1'b0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0; awaddr = 0; araddr = 0;
    wdata = 0; wstrb = 0; hiEn = 0; hiOut = 0; loEn = 0; loOut = 0; ext = 8'h01; gVal = 4'h5; gEn = 4'h1;
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    rdChk(OFS_DIR, 32'h000000ff, RESP_OKAY);
    rdChk(OFS_ANALOG, 32'h000000ff, RESP_OKAY);
    rdChk(OFS_LATCH, 32'h00000000, RESP_OKAY);
    // Pin 0 is high outside, but analog mode after reset hides it
    rdChk(OFS_PIN_LEVEL, 32'h00000000, RESP_OKAY);
    wr(OFS_STEER, 32'h000000ff, 4'hf, RESP_OKAY);
    rdChk(OFS_STEER, 32'h00000023, RESP_OKAY);
    wr(8'h14, 32'h000000ff, 4'hf, RESP_SLVERR);
    rdChk(8'h14, 32'h00000000, RESP_SLVERR);
    wr(OFS_ANALOG, 32'h00000000, 4'hf, RESP_OKAY);
    settle();
    rdChk(OFS_PIN_LEVEL, 32'h00000001, RESP_OKAY);
    chk(32'(ss), 32'h1);
    chk(32'({guardPinEn, guardPinOut}), 32'h2a);
    gEn <= 4'h9;
    wr(OFS_STEER, 32'h00000000, 4'hf, RESP_OKAY);
    settle();
    chk(32'(ss), 32'h0);
    chk(32'({guardPinEn, guardPinOut}), 32'h95);
    rdChk(OFS_DIR, 32'h000000ff, RESP_OKAY);
    wr(OFS_LATCH, 32'h000000a5, 4'hf, RESP_OKAY);
    rdChk(OFS_LATCH, 32'h000000a5, RESP_OKAY);
    wr(OFS_PIN_LEVEL, 32'h0000005a, 4'hf, RESP_OKAY);
    rdChk(OFS_LATCH, 32'h0000005a, RESP_OKAY);
    wr(OFS_DIR, 32'h00000000, 4'hf, RESP_OKAY);
    // Lane 0 not strobed: direction must keep its value
    wr(OFS_DIR, 32'h000000ff, 4'h0, RESP_OKAY);
    rdChk(OFS_DIR, 32'h00000008, RESP_OKAY);
    settle();
    chk(32'({padOe, padOut & padOe}), 32'hf752);
    rdChk(OFS_PIN_LEVEL, 32'h00000052, RESP_OKAY);
    // Analog on the low nibble while pins 0..2 of it still drive
    wr(OFS_ANALOG, 32'h0000000f, 4'hf, RESP_OKAY);
    settle();
    rdChk(OFS_PIN_LEVEL, 32'h00000050, RESP_OKAY);
    chk(32'({padOe, digitalIn}), 32'hf750);
    chk(32'(analogSel), 32'h0000000f);
    wr(OFS_PIN_LEVEL, 32'h00000000, 4'h0, RESP_OKAY);
    rdChk(OFS_LATCH, 32'h00000050, RESP_OKAY);
    // Competing claims: bit 1 both sources, bit 4 only the low one
    @(posedge clk_sys);
    hiEn <= 8'h02; hiOut <= 8'h02; loEn <= 8'h12; loOut <= 8'h00;
    settle();
    chk(32'(padOut & padOe), 32'h42);
    rdChk(OFS_PIN_LEVEL, 32'h00000040, RESP_OKAY);
    results();
  end
endmodule
